/* core/mics_top.sv */
// Integrator-comb decimator with stream sink, stream source and AHB-Lite registers.
// Assumes a single clock mclk and a synchronous active-high reset rst.
`timescale 1ns/10ps
module mics_top
  import mics_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic signed [MICS_IN_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_group_first_marker,
  input wire logic in_group_last_marker,
  input wire logic [1:0] in_error,
  output logic signed [MICS_OUT_W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [MICS_CH_W-1:0] out_channel,
  output logic out_group_first_marker,
  output logic out_group_last_marker,
  output logic [1:0] out_error
);
  // ==========================================================
  // Build-option legality
  function automatic logic cfg_ok(input logic int_mem, input logic dif_mem,
                                  input logic [MICS_PIPE_W-1:0] pipe);
    logic ok;
    ok = 1'b1;
    if (dif_mem && !(MICS_DIFF_DELAY * MICS_CHANNELS * MICS_INTERFACES > MICS_MEM_THRESH))
      ok = 1'b0;
    if (int_mem && !(MICS_CHANNELS > MICS_MEM_THRESH))
      ok = 1'b0;
    if (int'(pipe) < MICS_PIPE_MIN || int'(pipe) > MICS_PIPE_MAX)
      ok = 1'b0;
    if (int'(pipe) > MICS_PIPE_MIN && MICS_CHANNELS < MICS_PIPE_CH_MIN)
      ok = 1'b0;
    if (int'(pipe) > MICS_PIPE_MIN && int_mem && MICS_CHANNELS < MICS_PIPE_MEM_CH_MIN)
      ok = 1'b0;
    if (int_mem && int'(pipe) > MICS_CHANNELS - MICS_PIPE_MEM_SLACK)
      ok = 1'b0;
    if (!int_mem && int'(pipe) > MICS_CHANNELS)
      ok = 1'b0;
    return ok;
  endfunction : cfg_ok

  // ==========================================================
  // AHB-Lite slave
  logic ph_wr_r, ph_rd_r;
  logic [7:0] ph_addr_r;
  logic [7:0] ctrl_r;
  logic [MICS_RATE_W-1:0] rate_r;
  logic [MICS_EV_W-1:0] irq_st_r, irq_mask_r, ev;
  logic [31:0] rdata_r;
  wire addr_ph = hsel && hready && htrans[1];
  wire [MICS_PIPE_W-1:0] pipe_sel = ctrl_r[MICS_CTRL_PIPE_LSB +: MICS_PIPE_W];
  wire cfg_good = cfg_ok(ctrl_r[MICS_CTRL_INT_MEM], ctrl_r[MICS_CTRL_DIF_MEM], pipe_sel);
  wire [MICS_EV_W-1:0] w1c = (ph_wr_r && ph_addr_r == MICS_A_IRQ) ?
                             hwdata[MICS_EV_W-1:0] : '0;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(irq_st_r & irq_mask_r);

  // Address phase capture and register writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_addr_r <= '0;
      ctrl_r <= {1'b0, MICS_PIPE_W'(MICS_PIPE_MIN), 4'h0};
      rate_r <= MICS_RATE_RST;
      irq_mask_r <= '0;
    end else begin
      ph_wr_r <= addr_ph && hwrite;
      ph_rd_r <= addr_ph && !hwrite;
      ph_addr_r <= haddr;
      if (ph_wr_r && ph_addr_r == MICS_A_CTRL) ctrl_r <= hwdata[7:0];
      if (ph_wr_r && ph_addr_r == MICS_A_RATE && hwdata[15:0] >= MICS_RATE_MIN)
        rate_r <= hwdata[15:0];
      if (ph_wr_r && ph_addr_r == MICS_A_MASK) irq_mask_r <= hwdata[MICS_EV_W-1:0];
    end
  end

  // Sticky events, set wins over write-one clear
  always_ff @(posedge mclk) begin
    if (rst) irq_st_r <= '0;
    else irq_st_r <= (irq_st_r & ~w1c) | ev;
  end

  // Read mux, registered in the address phase
  logic [31:0] rd_mux;
  logic [1:0] last_err_r;
  logic [MICS_CH_W-1:0] in_ch_r;
  always_comb begin
    unique case (haddr)
      MICS_A_CTRL: rd_mux = {24'h0, ctrl_r};
      MICS_A_RATE: rd_mux = {16'h0, rate_r};
      MICS_A_STAT: rd_mux = {25'h0, cfg_good, last_err_r, 1'b0, in_ch_r};
      MICS_A_IRQ: rd_mux = {29'h0, irq_st_r};
      MICS_A_MASK: rd_mux = {29'h0, irq_mask_r};
      MICS_A_CFG: rd_mux = {8'h0, 8'(MICS_CHANNELS), 8'(MICS_STAGES), 8'(MICS_DIFF_DELAY)};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (rst) rdata_r <= '0;
    else if (addr_ph && !hwrite) rdata_r <= rd_mux;
  end
  assign hrdata = rdata_r;

  // ==========================================================
  // Sink side: channel tracking and error checks
  logic [MICS_CH_W-1:0] in_ch_nxt;
  logic [MICS_RATE_W-1:0] dec_cnt_r;
  logic out_full_r;
  wire in_fire = in_valid && in_ready;
  // Stall input while a finished result is waiting on the source side
  assign in_ready = !out_full_r || out_ready;
  wire last_ch = (in_ch_r == MICS_CH_W'(MICS_CHANNELS - 1));
  logic [1:0] err_now;
  always_comb begin
    err_now = in_error;
    if (in_ch_r == '0 && !in_group_first_marker) err_now = MICS_ERR_NO_FIRST;
    else if (last_ch && !in_group_last_marker) err_now = MICS_ERR_NO_LAST;
    else if (!last_ch && in_group_last_marker) err_now = MICS_ERR_OTHER;
  end
  // First marker resynchronises to channel 0
  assign in_ch_nxt = in_group_first_marker ? MICS_CH_W'(1) :
                     (last_ch ? '0 : in_ch_r + MICS_CH_W'(1));
  wire cur_ch_zero_ok = in_group_first_marker || in_ch_r == '0;
  wire [MICS_CH_W-1:0] use_ch = in_group_first_marker ? '0 : in_ch_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      in_ch_r <= '0;
      last_err_r <= MICS_ERR_NONE;
    end else if (in_fire) begin
      in_ch_r <= in_ch_nxt;
      last_err_r <= err_now;
    end
  end

  // ==========================================================
  // Integrators per channel, register storage, configurable pipe
  logic signed [MICS_OUT_W-1:0] integ_r [MICS_STAGES][MICS_CHANNELS];
  logic signed [MICS_OUT_W-1:0] comb_r [MICS_STAGES][MICS_CHANNELS];
  logic signed [MICS_OUT_W-1:0] ival [MICS_STAGES+1];
  logic signed [MICS_OUT_W-1:0] cval [MICS_STAGES+1];
  wire dec_hit = (dec_cnt_r == rate_r - MICS_RATE_W'(1));
  assign ival[0] = MICS_OUT_W'(in_data);
  genvar s;
  generate
    for (s = 0; s < MICS_STAGES; s++) begin : g_stage
      assign ival[s+1] = integ_r[s][use_ch] + ival[s];
      assign cval[s+1] = cval[s] - comb_r[s][use_ch];
      always_ff @(posedge mclk) begin
        if (rst) begin
          for (int c = 0; c < MICS_CHANNELS; c++) begin
            integ_r[s][c] <= '0;
            comb_r[s][c] <= '0;
          end
        end else if (in_fire) begin
          integ_r[s][use_ch] <= ival[s+1];
          if (dec_hit) comb_r[s][use_ch] <= cval[s];
        end
      end
    end
  endgenerate
  assign cval[0] = ival[MICS_STAGES];

  // Decimation phase advances once per full group
  always_ff @(posedge mclk) begin
    if (rst) dec_cnt_r <= '0;
    else if (in_fire && last_ch && !in_group_first_marker)
      dec_cnt_r <= dec_hit ? '0 : dec_cnt_r + MICS_RATE_W'(1);
  end

  // Selectable latency line for results, 1 to 4 stages deep
  logic [MICS_PIPE_MAX-1:0] pv_r;
  logic signed [MICS_OUT_W-1:0] pd_r [MICS_PIPE_MAX];
  logic [MICS_CH_W-1:0] pc_r [MICS_PIPE_MAX];
  logic [1:0] pe_r [MICS_PIPE_MAX];
  wire [MICS_PIPE_W-1:0] pipe_eff = cfg_good ? pipe_sel : MICS_PIPE_W'(MICS_PIPE_MIN);
  always_ff @(posedge mclk) begin
    if (rst) pv_r <= '0;
    else if (in_ready) pv_r <= {pv_r[MICS_PIPE_MAX-2:0], in_fire && dec_hit};
  end
  always_ff @(posedge mclk) begin
    if (in_ready) begin
      pd_r[0] <= cval[MICS_STAGES];
      pc_r[0] <= use_ch;
      pe_r[0] <= err_now;
      for (int i = 1; i < MICS_PIPE_MAX; i++) begin
        pd_r[i] <= pd_r[i-1];
        pc_r[i] <= pc_r[i-1];
        pe_r[i] <= pe_r[i-1];
      end
    end
  end
  wire [MICS_CH_W-1:0] ptap = MICS_CH_W'(pipe_eff - MICS_PIPE_W'(1));
  wire tap_v = pv_r[ptap[1:0]];

  // ==========================================================
  // Source side output register, held until taken
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_full_r <= 1'b0;
      out_data <= '0;
      out_channel <= '0;
      out_error <= MICS_ERR_NONE;
    end else if (in_ready) begin
      out_full_r <= tap_v;
      out_data <= pd_r[ptap[1:0]];
      out_channel <= pc_r[ptap[1:0]];
      out_error <= pe_r[ptap[1:0]];
    end
  end
  assign out_valid = out_full_r;
  assign out_group_first_marker = out_full_r && out_channel == '0;
  assign out_group_last_marker = out_full_r && out_channel == MICS_CH_W'(MICS_CHANNELS - 1);

  assign ev[MICS_EV_IN_ERR] = in_fire && err_now != MICS_ERR_NONE;
  assign ev[MICS_EV_OUT_GRP] = out_valid && out_ready && out_group_last_marker;
  assign ev[MICS_EV_CFG_BAD] = !cfg_good;

  // ==========================================================
  // Checks
  AST_HOLD: assert property (@(posedge mclk) disable iff (rst)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("result changed before acceptance");
  AST_BP: assert property (@(posedge mclk) disable iff (rst)
    out_valid && !out_ready |-> !in_ready)
    else $error("input accepted under backpressure");
  AST_HALT: assert property (@(posedge mclk) disable iff (rst)
    !in_valid |=> $stable(in_ch_r))
    else $error("channel advanced without valid");
  AST_NOFIRST: assert property (@(posedge mclk) disable iff (rst)
    in_fire && in_ch_r == '0 && !in_group_first_marker |=> last_err_r == MICS_ERR_NO_FIRST)
    else $error("missing first marker not flagged");
  AST_WRAP: assert property (@(posedge mclk) disable iff (rst)
    in_fire && last_ch && !in_group_first_marker |=> in_ch_r == '0)
    else $error("channel did not wrap");
  AST_PIPE: assert property (@(posedge mclk) disable iff (rst)
    pipe_sel > MICS_PIPE_W'(MICS_PIPE_MAX) |-> !cfg_good)
    else $error("illegal pipeline depth accepted");
  AST_MEM5: assert property (@(posedge mclk) disable iff (rst)
    ctrl_r[MICS_CTRL_INT_MEM] && int'(pipe_sel) > MICS_CHANNELS - MICS_PIPE_MEM_SLACK
    |-> !cfg_good)
    else $error("memory pipeline cap not enforced");
  AST_IRQ: assert property (@(posedge mclk) disable iff (rst)
    ev[MICS_EV_IN_ERR] |=> irq_st_r[MICS_EV_IN_ERR])
    else $error("error event not latched");
  COV_OUT: cover property (@(posedge mclk) out_valid && out_ready);
  COV_BP: cover property (@(posedge mclk) out_valid && !out_ready ##1 out_ready);
  COV_ERR: cover property (@(posedge mclk) ev[MICS_EV_IN_ERR]);
endmodule : mics_top

/* core/mics_pkg.sv */
// Constants shared by the multichannel integrator-comb stream block.
// Assumes one clock domain and software access over an AHB-Lite slave.
// Function
// - Comb delay store in memory only above four
// - Integrator store in memory only above four channels
// - Integrator pipeline depth selectable from one to four
// - Pipelining needs two channels, six with memory
// - Pipeline depth capped by channels, minus five memory
// - One symbol per interface per beat
// - Two-bit error code meanings fixed
// - Samples enter sink port, results leave source
// - Packets are channel-interleaved sample groups
// - Withheld ready stalls the sending side
// - Zero accept delay, data held until taken
// - No input valid means processing halts; results already in the latency line still shift out while in_ready is high
package mics_pkg;
  // ==========================================================
  // Build figures
  localparam int MICS_CHANNELS = 8;
  localparam int MICS_INTERFACES = 1;
  localparam int MICS_DIFF_DELAY = 1;
  localparam int MICS_STAGES = 3;
  localparam int MICS_IN_W = 16;
  localparam int MICS_OUT_W = 32;
  localparam int MICS_RATE_W = 16;
  localparam int MICS_CH_W = 3;
  localparam int MICS_PIPE_W = 3;
  localparam int MICS_MEM_THRESH = 4;
  localparam int MICS_PIPE_MIN = 1;
  localparam int MICS_PIPE_MAX = 4;
  localparam int MICS_PIPE_CH_MIN = 2;
  localparam int MICS_PIPE_MEM_CH_MIN = 6;
  localparam int MICS_PIPE_MEM_SLACK = 5;
  localparam logic [15:0] MICS_RATE_RST = 16'h0004;
  localparam logic [15:0] MICS_RATE_MIN = 16'h0002;
  localparam int MICS_ACCEPT_DELAY_CYCLES = 0;
  // ==========================================================
  // Error codes
  localparam logic [1:0] MICS_ERR_NONE = 2'h0;
  localparam logic [1:0] MICS_ERR_NO_FIRST = 2'h1;
  localparam logic [1:0] MICS_ERR_NO_LAST = 2'h2;
  localparam logic [1:0] MICS_ERR_OTHER = 2'h3;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] MICS_A_CTRL = 8'h00;
  localparam logic [7:0] MICS_A_RATE = 8'h04;
  localparam logic [7:0] MICS_A_STAT = 8'h08;
  localparam logic [7:0] MICS_A_IRQ = 8'h0c;
  localparam logic [7:0] MICS_A_MASK = 8'h10;
  localparam logic [7:0] MICS_A_CFG = 8'h14;
  // Control bits
  localparam int MICS_CTRL_INT_MEM = 0;
  localparam int MICS_CTRL_DIF_MEM = 1;
  localparam int MICS_CTRL_PIPE_LSB = 4;
  // Event bits
  localparam int MICS_EV_IN_ERR = 0;
  localparam int MICS_EV_OUT_GRP = 1;
  localparam int MICS_EV_CFG_BAD = 2;
  localparam int MICS_EV_W = 3;
  typedef enum logic [1:0] {
    MICS_ST_IDLE = 2'b00,
    MICS_ST_RUN = 2'b01,
    MICS_ST_SEND = 2'b11
  } mics_state_t;
endpackage : mics_pkg

/* verif/mics_partner.sv */
// Upstream sample source and downstream result sink for the stream ports.
// Assumes it shares mclk and rst with the block under test.
`timescale 1ns/10ps
module mics_partner
  import mics_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] groups,
  input wire logic [1:0] err_code,
  input wire logic stall,
  input wire logic in_ready,
  output logic signed [MICS_IN_W-1:0] in_data,
  output logic in_valid,
  output logic in_group_first_marker,
  output logic in_group_last_marker,
  output logic [1:0] in_error,
  output logic out_ready
);
  logic [MICS_CH_W-1:0] ch_r;
  logic [7:0] left_r;
  logic [1:0] tick_r = 2'h0;
  // ==========================================================
  // Source walks ch0..ch7 per group; sink takes one beat in four when stalled
  always @(posedge mclk) begin : drive
    logic [MICS_CH_W-1:0] nch;
    logic [7:0] nleft;
    logic take;
    take = in_valid && in_ready;
    nch = take ? ch_r + 1'b1 : ch_r;
    nleft = start ? groups : (take && ch_r == MICS_CH_W'(MICS_CHANNELS-1)) ? left_r - 8'h01 : left_r;
    tick_r <= tick_r + 2'h1;
    out_ready <= !stall || tick_r == 2'h3;
    ch_r <= rst ? '0 : nch;
    left_r <= rst ? 8'h00 : nleft;
    in_valid <= !rst && nleft != 8'h00;
    // Idle data toggles so a stale sample is never mistaken for a live one
    in_data <= rst ? '0 : (nleft != 8'h00) ? MICS_IN_W'(nch) - MICS_IN_W'(3) : ~in_data;
    in_group_first_marker <= nch == '0;
    in_group_last_marker <= nch == MICS_CH_W'(MICS_CHANNELS-1);
    in_error <= err_code;
  end
endmodule : mics_partner

/* verif/mics_top_tb.sv */
// Self-checking bench: registers over AHB-Lite, stream traffic and interrupts.
// Assumes mics_partner on the stream ports and one 250 MHz clock.
`timescale 1ns/10ps
module mics_top_tb
  import mics_pkg::*;
;
  logic mclk, rst, hsel, hwrite, hreadyout, hresp, irq, start, stall;
  logic [7:0] haddr, groups;
  logic [1:0] htrans, err_code, in_error, out_error;
  logic [2:0] hsize, out_channel, exp_ch;
  logic [31:0] hwdata, hrdata, held_r;
  logic signed [MICS_IN_W-1:0] in_data;
  logic signed [MICS_OUT_W-1:0] out_data;
  logic in_valid, in_ready, in_first, in_last, out_valid, out_ready, out_first, out_last;
  logic hold_r = 1'b0;
  logic [31:0] res [8];
  int err_count = 0;
  int samples_checked = 0;
  int beats = 0;
  mics_top dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .in_data(in_data), .in_valid(in_valid),
    .in_ready(in_ready), .in_group_first_marker(in_first), .in_group_last_marker(in_last),
    .in_error(in_error), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_channel(out_channel), .out_group_first_marker(out_first),
    .out_group_last_marker(out_last), .out_error(out_error));
  mics_partner u_src (.mclk(mclk), .rst(rst), .start(start), .groups(groups),
    .err_code(err_code), .stall(stall), .in_ready(in_ready), .in_data(in_data),
    .in_valid(in_valid), .in_group_first_marker(in_first), .in_group_last_marker(in_last),
    .in_error(in_error), .out_ready(out_ready));
  // ==========================================================
  // Clock and shared helpers
  always #2 mclk = ~mclk;
  task summarize;
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= a; hsize <= 3'h2;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0; hwdata <= d;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    q = hrdata;
    if (n >= 100) begin err_count++; summarize(); end
  endtask : ahb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr
  task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rd_chk
  task run(input logic [7:0] g);
    int n, tgt;
    tgt = beats + g / 4 * 8;
    n = 0;
    start <= 1'b1; groups <= g;
    @(posedge mclk);
    start <= 1'b0;
    do begin @(posedge mclk); n++; end while (beats < tgt && n < 3000);
    if (n >= 3000) begin err_count++; summarize(); end
  endtask : run
  // ==========================================================
  // Result monitor at mid-cycle: order, markers, error code, hold under stall
  always @(negedge mclk) begin
    if (rst) exp_ch = 3'h0;
    else begin
      if (hold_r) chk(out_data, held_r);
      hold_r = out_valid === 1'b1 && out_ready !== 1'b1;
      held_r = out_data;
      if (hold_r) chk(in_ready, 1'b0);
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
        chk(out_channel, exp_ch);
        chk({out_first, out_last}, {exp_ch == 3'h0, exp_ch == 3'h7});
        chk(out_error, err_code);
        res[exp_ch] = out_data;
        exp_ch = exp_ch + 3'h1;
        beats++;
      end
    end
  end
  // ==========================================================
  // Scenarios
  task sc_regs;
    logic [7:0] cv [6] = '{8'h00, 8'h10, 8'h40, 8'h50, 8'h31, 8'h41};
    logic [5:0] ok = 6'b010110;
    rd_chk(MICS_A_CTRL, 32'h73, 32'h10);
    rd_chk(MICS_A_RATE, 32'hffff, 32'h4);
    wr(MICS_A_RATE, 32'h1);
    rd_chk(MICS_A_RATE, 32'hffff, 32'h4);
    rd_chk(8'h40, 32'hffffffff, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(MICS_A_CTRL, {24'h0, cv[i]});
      rd_chk(MICS_A_STAT, 32'h40, {25'h0, ok[i], 6'h0});
    end
    wr(MICS_A_CTRL, 32'h12);
    rd_chk(MICS_A_IRQ, 32'h4, 32'h4);
    wr(MICS_A_IRQ, 32'h4);
    rd_chk(MICS_A_IRQ, 32'h4, 32'h0);
  endtask : sc_regs
  task sc_stream;
    wr(MICS_A_MASK, 32'h2);
    for (int d = 1; d <= 4; d++) begin
      wr(MICS_A_CTRL, 32'(d) << 4);
      stall <= (d == 4);
      run(8'd24);
      stall <= 1'b0;
      for (int c = 0; c < 8; c++) chk(res[c], 32'((c - 3) * 64));
      @(posedge mclk);
      chk(irq, 1'b1);
      wr(MICS_A_IRQ, 32'h2);
      @(posedge mclk);
      chk(irq, 1'b0);
    end
  endtask : sc_stream
  task sc_err;
    wr(MICS_A_MASK, 32'h1);
    for (int e = 1; e <= 3; e++) begin
      err_code <= 2'(e);
      run(8'd4);
      err_code <= 2'h0;
      rd_chk(MICS_A_STAT, 32'h30, 32'(e) << 4);
    end
    @(posedge mclk);
    chk(irq, 1'b1);
    wr(MICS_A_MASK, 32'h0);
    @(posedge mclk);
    chk(irq, 1'b0);
    wr(MICS_A_IRQ, 32'h1);
    rd_chk(MICS_A_IRQ, 32'h1, 32'h0);
  endtask : sc_err
  // ==========================================================
  // Main sequence
  initial begin
    mclk = 1'b0; rst = 1'b1; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h0; hwdata = 32'h0; start = 1'b0; groups = 8'h00; err_code = 2'h0; stall = 1'b0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    sc_regs();
    sc_stream();
    sc_err();
    summarize();
  end
endmodule : mics_top_tb
